// file: design/rx_mux_pkg.sv
// What this block does
// - GMII uses a single-rate 125 MHz receive clock.
// - RGMII clock is DDR at 125, 25 or 2.5 MHz by speed.
// - Rate bit 1 or valid pin high at reset: two 62.5 MHz clocks.
// - Rate bit 0 and valid pin low at reset: one 125 MHz clock.
// - RTBI uses a 125 MHz clock with data on both edges.
// - MII clock runs at 25 MHz or 2.5 MHz by speed.
// - Role 1 takes the receive clock in; role 0 drives it out.
// - Data pins are configuration inputs in reset, driven afterwards.
// - GMII puts eight data bits on eight pins at the rising edge.
// - MII and slow RGMII put a nibble low, upper pins undriven.
// - RGMII-1000 puts low nibble on rise, high nibble on fall.
// - Normal TBI maps bits 7:0, 8, 9 on two opposed clocks.
// - One-clock TBI uses the same mapping on one 125 MHz clock.
// - RTBI rising edge: bits 3:0 on low pins, bit 4 on valid.
// - RTBI falling edge: bits 8:5 low pins, bit 9 valid, upper undriven.
// - RGMII carries receive control on the valid pin at both edges.
// - RGMII and RTBI leave the error pin undriven.
package rx_mux_pkg;

    // ==========================================
    // Modes and carriers
    typedef enum logic [2:0] {
        MODE_GMII = 3'b000,
        MODE_RGMII = 3'b001,
        MODE_TBI = 3'b010,
        MODE_RTBI = 3'b011,
        MODE_MII = 3'b100
    } if_mode_t;

    typedef enum logic [1:0] {
        SPEED_10 = 2'b00,
        SPEED_100 = 2'b01,
        SPEED_1000 = 2'b10
    } speed_t;

    typedef struct packed {
        if_mode_t mode;
        speed_t speed;
        logic rate_sel;
        logic role_sel;
    } cfg_t;

    typedef struct packed {
        logic [9:0] data;
        logic dv;
        logic er;
    } rx_word_t;

    typedef struct packed {
        logic [7:0] rxd;
        logic dv;
        logic er;
    } pins_t;

    // ==========================================
    // Roles and reset values
    localparam logic ROLE_DTE = 1'b1;
    localparam logic ROLE_DCE = 1'b0;
    localparam pins_t PINS_RESET = '{rxd: 8'h00, dv: 1'b0, er: 1'b0};
    localparam rx_word_t IDLE_WORD = '{data: 10'h000, dv: 1'b0, er: 1'b0};
    localparam int FIFO_DEPTH = 8;

    // ==========================================
    // Clock rates, in kHz, and half periods in link clock cycles
    localparam int LINK_CLK_KHZ = 250000;
    localparam int CLK_125M_KHZ = 125000;
    localparam int CLK_62M5_KHZ = 62500;
    localparam int CLK_25M_KHZ = 25000;
    localparam int CLK_2M5_KHZ = 2500;
    localparam logic [7:0] HALF_125M = 8'(LINK_CLK_KHZ / (2 * CLK_125M_KHZ));
    localparam logic [7:0] HALF_62M5 = 8'(LINK_CLK_KHZ / (2 * CLK_62M5_KHZ));
    localparam logic [7:0] HALF_25M = 8'(LINK_CLK_KHZ / (2 * CLK_25M_KHZ));
    localparam logic [7:0] HALF_2M5 = 8'(LINK_CLK_KHZ / (2 * CLK_2M5_KHZ));

endpackage

// file: design/parallel_rx_output_mux.sv
`timescale 1ns/1ps

// ==========================================
// Dual-clock FIFO, gray pointers
module rx_async_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic wr_clk,
    input wire logic wr_rst,
    input wire logic wr_valid,
    input wire logic [WIDTH-1:0] wr_data,
    output logic wr_ready,
    input wire logic rd_clk,
    input wire logic rd_rst,
    output logic rd_valid,
    output logic [WIDTH-1:0] rd_data,
    input wire logic rd_ready
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("DEPTH must be a power of two, at least 4");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wbin, wgray, rbin, rgray;
    logic [AW:0] next_wbin, next_wgray, next_rbin, next_rgray;
    logic [AW:0] rgray_s1, rgray_s2, wgray_s1, wgray_s2;
    logic next_wr_ready;
    logic wpush, rpop;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    always_comb begin
        wpush = wr_valid && wr_ready;
        next_wbin = wbin + (AW + 1)'(wpush);
        next_wgray = to_gray(next_wbin);
        // Full seen one cycle early so ready is a plain flop
        next_wr_ready = next_wgray !=
            {~rgray_s2[AW:AW-1], rgray_s2[AW-2:0]};
        rd_valid = rgray != wgray_s2;
        rpop = rd_valid && rd_ready;
        next_rbin = rbin + (AW + 1)'(rpop);
        next_rgray = to_gray(next_rbin);
        rd_data = mem[rbin[AW-1:0]];
    end

    always_ff @(posedge wr_clk) begin
        if (wr_rst) begin
            wbin <= '0;
            wgray <= '0;
            wr_ready <= 1'b0;
            rgray_s1 <= '0;
            rgray_s2 <= '0;
        end else begin
            wbin <= next_wbin;
            wgray <= next_wgray;
            wr_ready <= next_wr_ready;
            rgray_s1 <= rgray;
            rgray_s2 <= rgray_s1;
        end
    end

    always_ff @(posedge wr_clk) begin
        if (wpush) begin
            mem[wbin[AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge rd_clk) begin
        if (rd_rst) begin
            rbin <= '0;
            rgray <= '0;
            wgray_s1 <= '0;
            wgray_s2 <= '0;
        end else begin
            rbin <= next_rbin;
            rgray <= next_rgray;
            wgray_s1 <= wgray;
            wgray_s2 <= wgray_s1;
        end
    end
endmodule // rx_async_fifo

// ==========================================
// Receive pin multiplexer
module parallel_rx_output_mux #(
    parameter int DEPTH = rx_mux_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire rx_mux_pkg::if_mode_t mode_sel,
    input wire rx_mux_pkg::speed_t speed_sel,
    input wire logic code_group_clock_rate_sel,
    input wire logic rx_clock_role_sel,
    input wire logic in_valid,
    input wire rx_mux_pkg::rx_word_t in_word,
    output logic in_ready,
    output logic [7:0] strap_rxd,
    output logic strap_dv,
    output logic strap_er,
    input wire logic rx_clk_i,
    output logic rx_clk_o,
    output logic rx_clk_oe,
    output logic rx_even_group_clock_o,
    output logic rx_even_group_clock_oe,
    input wire logic [7:0] rxd_i,
    output logic [7:0] rxd_o,
    output logic [7:0] rxd_oe,
    input wire logic dv_i,
    output logic dv_o,
    output logic dv_oe,
    input wire logic er_i,
    output logic er_o,
    output logic er_oe
);

    // ==========================================
    // Strap capture in the reference domain
    logic [9:0] pin_s1, pin_s2;
    logic [7:0] next_strap_rxd;
    logic next_strap_dv, next_strap_er;
    rx_mux_pkg::cfg_t cfg, next_cfg;

    always_comb begin
        next_strap_rxd = strap_rxd;
        next_strap_dv = strap_dv;
        next_strap_er = strap_er;
        if (rst) begin
            {next_strap_rxd, next_strap_dv, next_strap_er} = pin_s2;
        end
        next_cfg.mode = mode_sel;
        next_cfg.speed = speed_sel;
        // Either the strap or the select bit asks for normal TBI
        next_cfg.rate_sel = code_group_clock_rate_sel | strap_dv;
        next_cfg.role_sel = rx_clock_role_sel;
    end

    always_ff @(posedge ref_clk) begin
        pin_s1 <= {rxd_i, dv_i, er_i};
        pin_s2 <= pin_s1;
        strap_rxd <= next_strap_rxd;
        strap_dv <= next_strap_dv;
        strap_er <= next_strap_er;
        cfg <= next_cfg;
    end

    // ==========================================
    // Data path into the link domain
    logic link_rst_s1, link_rst;
    logic rd_valid, rd_ready;
    rx_mux_pkg::rx_word_t rd_word;

    rx_async_fifo #(
        .WIDTH($bits(rx_mux_pkg::rx_word_t)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .wr_clk(ref_clk),
        .wr_rst(rst),
        .wr_valid(in_valid),
        .wr_data(in_word),
        .wr_ready(in_ready),
        .rd_clk(link_clk),
        .rd_rst(link_rst),
        .rd_valid(rd_valid),
        .rd_data(rd_word),
        .rd_ready(rd_ready)
    );

    // ==========================================
    // Link domain synchronisers
    // Config is quasi-static; change it only while in reset
    rx_mux_pkg::cfg_t cfg_s1, cfg_l;
    logic clk_s1, clk_s2, clk_s3;

    always_ff @(posedge link_clk) begin
        link_rst_s1 <= rst;
        link_rst <= link_rst_s1;
        cfg_s1 <= cfg;
        cfg_l <= cfg_s1;
        clk_s1 <= rx_clk_i;
        clk_s2 <= clk_s1;
        clk_s3 <= clk_s2;
    end

    // ==========================================
    // Clock timing and pin launch
    logic [7:0] half, cnt, next_cnt;
    logic clk_ph, next_clk_ph;
    logic rise, fall, load, ddr, alt, dte;
    rx_mux_pkg::rx_word_t cur, next_cur, fresh;
    rx_mux_pkg::pins_t pins, next_pins;
    logic [7:0] next_rxd_oe;
    logic next_dv_oe, next_er_oe, next_clk_oe, next_even_oe;

    function automatic rx_mux_pkg::pins_t map_pins(
        input rx_mux_pkg::rx_word_t w,
        input rx_mux_pkg::cfg_t c,
        input logic falling,
        input rx_mux_pkg::pins_t old
    );
        rx_mux_pkg::pins_t p;
        p = old;
        unique case (c.mode)
            rx_mux_pkg::MODE_GMII: begin
                p = '{rxd: w.data[7:0], dv: w.dv, er: w.er};
            end
            rx_mux_pkg::MODE_MII: begin
                p = '{rxd: {4'h0, w.data[3:0]}, dv: w.dv,
                      er: w.er};
            end
            rx_mux_pkg::MODE_RGMII: begin
                if (!falling) begin
                    p = '{rxd: {4'h0, w.data[3:0]}, dv: w.dv,
                          er: 1'b0};
                end else begin
                    p.dv = w.dv ^ w.er;
                    if (c.speed == rx_mux_pkg::SPEED_1000) begin
                        p.rxd = {4'h0, w.data[7:4]};
                    end
                end
            end
            rx_mux_pkg::MODE_TBI: begin
                p = '{rxd: w.data[7:0], dv: w.data[8],
                      er: w.data[9]};
            end
            rx_mux_pkg::MODE_RTBI: begin
                if (!falling) begin
                    p = '{rxd: {4'h0, w.data[3:0]}, dv: w.data[4],
                          er: 1'b0};
                end else begin
                    p.rxd = {4'h0, w.data[8:5]};
                    p.dv = w.data[9];
                end
            end
            default: begin
                p = rx_mux_pkg::PINS_RESET;
            end
        endcase
        return p;
    endfunction

    always_comb begin
        unique case (cfg_l.mode)
            rx_mux_pkg::MODE_GMII: half = rx_mux_pkg::HALF_125M;
            rx_mux_pkg::MODE_RGMII: begin
                unique case (cfg_l.speed)
                    rx_mux_pkg::SPEED_1000: begin
                        half = rx_mux_pkg::HALF_125M;
                    end
                    rx_mux_pkg::SPEED_100: begin
                        half = rx_mux_pkg::HALF_25M;
                    end
                    default: begin
                        half = rx_mux_pkg::HALF_2M5;
                    end
                endcase
            end
            rx_mux_pkg::MODE_TBI: begin
                half = cfg_l.rate_sel ? rx_mux_pkg::HALF_62M5
                    : rx_mux_pkg::HALF_125M;
            end
            rx_mux_pkg::MODE_RTBI: half = rx_mux_pkg::HALF_125M;
            rx_mux_pkg::MODE_MII: begin
                half = (cfg_l.speed == rx_mux_pkg::SPEED_10)
                    ? rx_mux_pkg::HALF_2M5 : rx_mux_pkg::HALF_25M;
            end
            default: half = rx_mux_pkg::HALF_125M;
        endcase
        dte = cfg_l.role_sel == rx_mux_pkg::ROLE_DTE;
        ddr = cfg_l.mode == rx_mux_pkg::MODE_RTBI
            || cfg_l.mode == rx_mux_pkg::MODE_RGMII;
        // Normal TBI launches a group on each of the two opposed clocks
        alt = cfg_l.mode == rx_mux_pkg::MODE_TBI && cfg_l.rate_sel;
        next_cnt = cnt;
        next_clk_ph = clk_ph;
        rise = 1'b0;
        fall = 1'b0;
        if (dte) begin
            rise = clk_s2 && !clk_s3;
            fall = !clk_s2 && clk_s3;
            next_cnt = 8'h00;
            next_clk_ph = clk_s2;
        end else if (cnt >= half - 8'h01) begin
            next_cnt = 8'h00;
            next_clk_ph = !clk_ph;
            rise = !clk_ph;
            fall = clk_ph;
        end else begin
            next_cnt = cnt + 8'h01;
        end
        load = rise || (alt && fall);
        rd_ready = load && !link_rst;
        // Underrun sends an idle word rather than stalling the clock
        fresh = rd_valid ? rd_word : rx_mux_pkg::IDLE_WORD;
        next_cur = load ? fresh : cur;
        next_pins = pins;
        if (load) begin
            next_pins = map_pins(fresh, cfg_l, 1'b0, pins);
        end else if (fall && ddr) begin
            next_pins = map_pins(cur, cfg_l, 1'b1, pins);
        end
        next_rxd_oe = {{4{cfg_l.mode == rx_mux_pkg::MODE_GMII
            || cfg_l.mode == rx_mux_pkg::MODE_TBI}}, 4'hf};
        next_dv_oe = 1'b1;
        next_er_oe = !ddr;
        next_clk_oe = !dte;
        next_even_oe = alt;
        if (link_rst) begin
            next_cnt = 8'h00;
            next_clk_ph = 1'b0;
            next_cur = rx_mux_pkg::IDLE_WORD;
            next_pins = rx_mux_pkg::PINS_RESET;
            next_rxd_oe = 8'h00;
            next_dv_oe = 1'b0;
            next_er_oe = 1'b0;
            next_clk_oe = 1'b0;
            next_even_oe = 1'b0;
        end
    end

    always_ff @(posedge link_clk) begin
        cnt <= next_cnt;
        clk_ph <= next_clk_ph;
        cur <= next_cur;
        pins <= next_pins;
        rx_clk_o <= next_clk_ph;
        rx_even_group_clock_o <= !next_clk_ph;
        rx_clk_oe <= next_clk_oe;
        rx_even_group_clock_oe <= next_even_oe;
        rxd_o <= next_pins.rxd;
        dv_o <= next_pins.dv;
        er_o <= next_pins.er;
        rxd_oe <= next_rxd_oe;
        dv_oe <= next_dv_oe;
        er_oe <= next_er_oe;
    end
endmodule // parallel_rx_output_mux

// file: tb/rx_mux_checker.sv
`timescale 1ns/1ps

// ==========================================
// Pin checks at the device edge
module rx_mux_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire rx_mux_pkg::if_mode_t mode_sel,
    input wire logic rx_clock_role_sel,
    input wire logic rx_clk_o,
    input wire logic rx_clk_oe,
    input wire logic rx_even_group_clock_o,
    input wire logic rx_even_group_clock_oe,
    input wire logic [7:0] rxd_o,
    input wire logic [7:0] rxd_oe,
    input wire logic dv_oe,
    input wire logic er_oe
);
    a_role_drive: assert property (
        @(posedge link_clk) disable iff (rst)
        rx_clk_oe |-> rx_clock_role_sel == rx_mux_pkg::ROLE_DCE)
        else $error("clock driven in input role");
    a_err_undriven: assert property (
        @(posedge link_clk) disable iff (rst) mode_sel inside
        {rx_mux_pkg::MODE_RGMII, rx_mux_pkg::MODE_RTBI} |-> !er_oe)
        else $error("error pin driven");
    a_upper_undriven: assert property (
        @(posedge link_clk) disable iff (rst) mode_sel inside
        {rx_mux_pkg::MODE_MII, rx_mux_pkg::MODE_RGMII,
        rx_mux_pkg::MODE_RTBI} |-> rxd_oe[7:4] == 4'h0)
        else $error("upper pins driven");
    a_even_tbi: assert property (
        @(posedge link_clk) disable iff (rst) rx_even_group_clock_oe
        |-> mode_sel == rx_mux_pkg::MODE_TBI
        && rx_even_group_clock_o != rx_clk_o)
        else $error("even clock wrong");
    // Straps need the pins free from the fifth cycle of reset on
    a_pins_reset: assert property (
        @(posedge ref_clk) rst [*5] |-> rxd_oe == 8'h00 && !dv_oe)
        else $error("pins driven in reset");
    a_gmii_rate: assert property (
        @(posedge link_clk) disable iff (rst)
        rx_clk_oe && mode_sel == rx_mux_pkg::MODE_GMII
        |=> $changed(rx_clk_o))
        else $error("clock rate wrong");
    a_launch_edge: assert property (
        @(posedge link_clk) disable iff (rst)
        rx_clk_oe && $changed(rxd_o) |-> $changed(rx_clk_o))
        else $error("data off clock edge");
    a_gmii_width: assert property (
        @(posedge link_clk) disable iff (rst)
        dv_oe && mode_sel == rx_mux_pkg::MODE_GMII
        |-> rxd_oe == 8'hff && er_oe)
        else $error("gmii width");
endmodule // rx_mux_checker

bind parallel_rx_output_mux rx_mux_checker rx_mux_checker_inst (.ref_clk,
    .rst, .link_clk, .mode_sel, .rx_clock_role_sel, .rx_clk_o, .rx_clk_oe,
    .rx_even_group_clock_o, .rx_even_group_clock_oe, .rxd_o, .rxd_oe,
    .dv_oe, .er_oe);

// file: tb/rx_mac_model.sv
`timescale 1ns/1ps

// ==========================================
// Far side: clock source and pin straps
module rx_mac_model #(
    parameter int HALF_NS = 260
) (
    input wire logic link_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [9:0] strap,
    input wire logic rx_clk_o,
    input wire logic rx_clk_oe,
    input wire logic [7:0] rxd_o,
    input wire logic [7:0] rxd_oe,
    input wire logic dv_o,
    input wire logic dv_oe,
    input wire logic er_o,
    input wire logic er_oe,
    output logic rx_clk_i,
    output logic [7:0] rxd_i,
    output logic dv_i,
    output logic er_i
);
    logic clk = 1'b0;
    logic flip = 1'b0;
    // Clock stands still outside bench frames
    always #(HALF_NS) clk = clk_en ? !clk : 1'b0;
    always @(posedge link_clk) flip <= !flip;
    // Undriven pins wander so stale values never pass
    assign rx_clk_i = rx_clk_oe ? rx_clk_o : clk;
    assign rxd_i = (rxd_oe & rxd_o)
        | (~rxd_oe & (rst ? strap[7:0] : {8{flip}}));
    assign dv_i = dv_oe ? dv_o : (rst ? strap[8] : !flip);
    assign er_i = er_oe ? er_o : (rst ? strap[9] : flip);
endmodule // rx_mac_model

// file: tb/parallel_rx_output_mux_tb_top.sv
`timescale 1ns/1ps

module parallel_rx_output_mux_tb_top;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    rx_mux_pkg::if_mode_t mode_sel = rx_mux_pkg::MODE_GMII;
    rx_mux_pkg::speed_t speed_sel = rx_mux_pkg::SPEED_1000;
    logic code_group_clock_rate_sel = 1'b0;
    logic rx_clock_role_sel = 1'b0;
    logic in_valid = 1'b0;
    rx_mux_pkg::rx_word_t in_word = rx_mux_pkg::IDLE_WORD;
    logic clk_en = 1'b0;
    logic [9:0] strap = 10'h000;
    logic in_ready, strap_dv, strap_er, rx_clk_i, rx_clk_o, rx_clk_oe;
    logic rx_even_group_clock_o, rx_even_group_clock_oe;
    logic [7:0] strap_rxd, rxd_i, rxd_o, rxd_oe;
    logic dv_i, dv_o, dv_oe, er_i, er_o, er_oe;
    int fails = 0;
    int cmp_count = 0;
    // Enough words to fill the buffer even at the fastest drain rate
    localparam int N_WORDS = 20;
    rx_mux_pkg::rx_word_t q[$];
    wire [19:0] obs = {rxd_o & rxd_oe, dv_o, er_o & er_oe, rxd_oe, dv_oe,
        er_oe};

    always #20 ref_clk = !ref_clk;
    initial begin
        #7;
        forever #16 link_clk = !link_clk;
    end

    parallel_rx_output_mux parallel_rx_output_mux_inst (.ref_clk, .rst,
        .link_clk, .mode_sel, .speed_sel, .code_group_clock_rate_sel,
        .rx_clock_role_sel, .in_valid, .in_word, .in_ready, .strap_rxd,
        .strap_dv, .strap_er, .rx_clk_i, .rx_clk_o, .rx_clk_oe,
        .rx_even_group_clock_o, .rx_even_group_clock_oe, .rxd_i, .rxd_o,
        .rxd_oe, .dv_i, .dv_o, .dv_oe, .er_i, .er_o, .er_oe);
    rx_mac_model rx_mac_model_inst (.link_clk, .rst, .clk_en, .strap,
        .rx_clk_o, .rx_clk_oe, .rxd_o, .rxd_oe, .dv_o, .dv_oe, .er_o,
        .er_oe, .rx_clk_i, .rxd_i, .dv_i, .er_i);

    // ==========================================
    // Checking and closing
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Expected pins for one word at one clock edge
    function automatic logic [19:0] want(rx_mux_pkg::rx_word_t w, logic f);
        logic [7:0] d;
        logic v;
        logic e;
        logic lo;
        logic ne;
        d = w.data[7:0];
        v = w.dv;
        e = w.er;
        ne = mode_sel inside {rx_mux_pkg::MODE_RGMII, rx_mux_pkg::MODE_RTBI};
        lo = ne || mode_sel == rx_mux_pkg::MODE_MII;
        if (ne && f) v = w.dv ^ w.er;
        if (ne && f && speed_sel == rx_mux_pkg::SPEED_1000) begin
            d = {4'h0, w.data[7:4]};
        end
        if (mode_sel == rx_mux_pkg::MODE_TBI) {e, v} = w.data[9:8];
        if (mode_sel == rx_mux_pkg::MODE_RTBI) begin
            {v, d} = f ? {w.data[9], 4'h0, w.data[8:5]}
                : {w.data[4], w.data[7:0]};
        end
        if (lo) d[7:4] = 4'h0;
        return {d, v, e & !ne, lo ? 8'h0f : 8'hff, 1'b1, !ne};
    endfunction

    // ==========================================
    // One mode: reset with straps, fill, drain, compare
    task automatic run(input rx_mux_pkg::cfg_t c, input logic sdv);
        rx_mux_pkg::rx_word_t w;
        rx_mux_pkg::rx_word_t wm;
        logic f;
        logic full;
        logic nt;
        int got;
        int khz;
        realtime t0;
        @(negedge ref_clk);
        rst = 1'b1;
        mode_sel = c.mode;
        speed_sel = c.speed;
        code_group_clock_rate_sel = c.rate_sel;
        rx_clock_role_sel = c.role_sel;
        strap = {1'($urandom), sdv, 8'($urandom)};
        nt = c.mode == rx_mux_pkg::MODE_TBI && (c.rate_sel || sdv);
        q.delete();
        got = 0;
        full = 1'b0;
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        chk(strap_rxd, strap[7:0]);
        chk(strap_dv, sdv);
        chk(strap_er, strap[9]);
        clk_en = c.role_sel;
        fork
            for (int i = 0; i < N_WORDS; i++) begin
                w = 12'($urandom);
                w.dv = 1'b1;
                w.data[8] = 1'b1;
                w.data[4] = 1'b1;
                in_valid = 1'b1;
                in_word = w;
                while (in_ready !== 1'b1) begin
                    full = i > 0;
                    @(negedge ref_clk);
                end
                q.push_back(w);
                @(negedge ref_clk);
            end
            for (int k = 0; k < 600 && got < N_WORDS; k++) begin
                if (c.role_sel) @(rx_clk_i);
                else @(rx_clk_o);
                f = c.role_sel ? !rx_clk_i : !rx_clk_o;
                // Input clock is resynced, so pins trail its edges
                if (c.role_sel) repeat (6) @(posedge link_clk);
                #1;
                if ((!f || nt) && dv_o === 1'b1 && q.size() > 0) begin
                    wm = q.pop_front();
                    got++;
                end
                if (got > 0) chk(obs, want(wm, f));
            end
        join
        in_valid = 1'b0;
        clk_en = 1'b0;
        chk(got, N_WORDS);
        chk(full, 1'b1);
        chk(rx_clk_oe, !c.role_sel);
        chk(rx_even_group_clock_oe, nt);
        khz = c.speed == rx_mux_pkg::SPEED_10 ? rx_mux_pkg::CLK_2M5_KHZ
            : c.speed == rx_mux_pkg::SPEED_100 ? rx_mux_pkg::CLK_25M_KHZ
            : nt ? rx_mux_pkg::CLK_62M5_KHZ : rx_mux_pkg::CLK_125M_KHZ;
        if (!c.role_sel) begin
            @(posedge rx_clk_o);
            t0 = $realtime;
            @(posedge rx_clk_o);
            chk(int'($realtime - t0),
                64 * (rx_mux_pkg::LINK_CLK_KHZ / (2 * khz)));
        end
        $display("Test mode %0d done", c.mode);
    endtask

    initial begin
        #400000;
        fails++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'hd936));
        run('{rx_mux_pkg::MODE_GMII, rx_mux_pkg::SPEED_1000, 1'b0,
            rx_mux_pkg::ROLE_DCE}, 1'b0);
        run('{rx_mux_pkg::MODE_RGMII, rx_mux_pkg::SPEED_1000, 1'b0,
            rx_mux_pkg::ROLE_DTE}, 1'b0);
        run('{rx_mux_pkg::MODE_TBI, rx_mux_pkg::SPEED_1000, 1'b1,
            rx_mux_pkg::ROLE_DCE}, 1'b0);
        run('{rx_mux_pkg::MODE_TBI, rx_mux_pkg::SPEED_1000, 1'b0,
            rx_mux_pkg::ROLE_DCE}, 1'b1);
        run('{rx_mux_pkg::MODE_TBI, rx_mux_pkg::SPEED_1000, 1'b0,
            rx_mux_pkg::ROLE_DCE}, 1'b0);
        run('{rx_mux_pkg::MODE_RTBI, rx_mux_pkg::SPEED_1000, 1'b0,
            rx_mux_pkg::ROLE_DCE}, 1'b0);
        run('{rx_mux_pkg::MODE_MII, rx_mux_pkg::SPEED_100, 1'b0,
            rx_mux_pkg::ROLE_DCE}, 1'b0);
        run('{rx_mux_pkg::MODE_RGMII, rx_mux_pkg::SPEED_100, 1'b0,
            rx_mux_pkg::ROLE_DCE}, 1'b0);
        run('{rx_mux_pkg::MODE_MII, rx_mux_pkg::SPEED_10, 1'b0,
            rx_mux_pkg::ROLE_DCE}, 1'b0);
        wrap_up();
    end
endmodule // parallel_rx_output_mux_tb_top
